// File: inc/lis_pkg.sv
package lis_pkg;

  localparam int STATUS_W = 4;
  localparam int TUNE_W = 16;

  // acquisition status codes
  localparam logic [STATUS_W-1:0] STATUS_WARMUP = 4'h8;
  localparam logic [STATUS_W-1:0] STATUS_TEMP_LO = 4'h6;
  localparam logic [STATUS_W-1:0] STATUS_OPT_LO = 4'h2;
  localparam logic [STATUS_W-1:0] STATUS_REACQ = 4'h1;
  localparam logic [STATUS_W-1:0] STATUS_LOCKED = 4'h0;
  localparam logic [STATUS_W-1:0] STATUS_STEP = 4'h1;

  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int QUAL_TIME_S = 5;
  localparam int QUAL_TICKS = QUAL_TIME_S / TICK_PERIOD_S;
  localparam int ALARM_TIME_S = 1;
  localparam int QUAL_W = 3;
  localparam logic [QUAL_W-1:0] QUAL_LAST = QUAL_W'(QUAL_TICKS - 1);

  localparam logic [TUNE_W-1:0] TUNE_NOMINAL = 16'h8000;
  localparam logic [TUNE_W-1:0] TUNE_MAX = 16'hffff;
  localparam logic [TUNE_W-1:0] TUNE_MIN = 16'h0000;
  localparam int STORE_DEPTH = 4;

  typedef enum logic [1:0] {
    PH_TEMP,
    PH_OPTIMISE,
    PH_LOCK,
    PH_DONE
  } lis_phase_t;

  typedef enum logic [2:0] {
    ST_RESTORE,
    ST_ACQUIRE,
    ST_QUALIFY,
    ST_LOCKED,
    ST_SLEEP
  } lis_state_t;

  typedef struct packed {
    logic valid;
    logic signed [TUNE_W-1:0] delta;
  } lis_corr_t;

  typedef struct packed {
    logic correct_en;
    logic [TUNE_W-1:0] tune;
  } lis_osc_ctl_t;

  function automatic lis_phase_t stage_of(input logic [STATUS_W-1:0] st);
    if (st >= STATUS_TEMP_LO) begin
      return PH_TEMP;
    end else if (st >= STATUS_OPT_LO) begin
      return PH_OPTIMISE;
    end else if (st != STATUS_LOCKED) begin
      return PH_LOCK;
    end
    return PH_DONE;
  endfunction

  function automatic logic [TUNE_W-1:0] sat_add(input logic [TUNE_W-1:0] a,
                                                input logic [TUNE_W-1:0] d);
    logic [TUNE_W+1:0] s;
    s = {2'b00, a} + {{2{d[TUNE_W-1]}}, d};
    if (s[TUNE_W+1]) begin
      return TUNE_MIN;
    end else if (s[TUNE_W]) begin
      return TUNE_MAX;
    end
    return s[TUNE_W-1:0];
  endfunction

endpackage

// File: logic/lis_tune_store.sv
`timescale 1ns/1ps
// keeps the most recent good tuning words in a small ring so writes spread over cells;
// contents, pointer and valid flag survive srst_in; erase_in clears only the pointer and valid flag, never the contents
module lis_tune_store #(
  parameter int DEPTH = lis_pkg::STORE_DEPTH,
  parameter int WIDTH = lis_pkg::TUNE_W
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic erase_in,
  input wire logic wr_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out
);
  import lis_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] last_ptr;
  logic valid;
  logic next_valid;
  logic [WIDTH-1:0] next_rd_data;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_valid = valid;
    last_ptr = (wr_ptr == '0) ? PTR_LAST : wr_ptr - 1'b1;
    next_rd_data = mem[last_ptr];
    if (erase_in) begin
      next_wr_ptr = '0;
      next_valid = 1'b0;
    end else if (wr_en_in && !srst_in) begin
      next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      next_valid = 1'b1;
      next_rd_data = wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    // no ring update during reset; read port keeps showing the stored word so that
    // the restore right after reset release sees the last good value
    if (wr_en_in && !erase_in && !srst_in) begin
      mem[wr_ptr] <= wr_data_in;
    end
    wr_ptr <= next_wr_ptr;
    valid <= next_valid;
    rd_data_out <= next_rd_data;
    rd_valid_out <= next_valid;
  end

endmodule // lis_tune_store

// File: logic/lis_lock_indicator.sv
`timescale 1ns/1ps
// Operation
// [RL1] power-up loads status with warm-up code 8
// [RL2] status steps down by one to 0
// [RL3] stages: temperature, optimise, then frequency lock
// [RL4] alarm pin high at power-on and status nonzero
// [RL5] pin stays high 5 s after status 0
// [RL6] pin rises within 1 s of fault
// [RL7] low-power mode: high asleep, low only awake-locked
// [RL8] 10 MHz output never gated by lock state
// [RL9] no oscillator corrections while status nonzero
// [RL10] reapply last-good tuning at power-up and recovery
// [RL11] one-second tick; nonzero status restarts qualification
module lis_lock_indicator #(
  parameter int TICK_CYCLES = lis_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic step_done_in,
  input wire logic lock_lost_in,
  input wire logic alarm_in,
  input wire logic low_power_duty_cycle_mode_in,
  input wire logic sleep_req_in,
  input wire logic nvm_erase_in,
  input wire lis_pkg::lis_corr_t corr_in,
  output logic lock_alarm_pin_out,
  output logic [lis_pkg::STATUS_W-1:0] status_out,
  output lis_pkg::lis_phase_t phase_out,
  output logic freq_out_en_out,
  output lis_pkg::lis_osc_ctl_t osc_ctl_out
);
  import lis_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int SYNC_N = 4;

  // pin inputs: two flip-flops before use
  logic [SYNC_N-1:0] sync_a;
  logic [SYNC_N-1:0] sync_b;
  logic lock_lost_s;
  logic alarm_s;
  logic mode_s;
  logic sleep_s;

  always_ff @(posedge sys_clk_in) begin
    sync_a <= {sleep_req_in, low_power_duty_cycle_mode_in, alarm_in, lock_lost_in};
    sync_b <= sync_a;
  end

  assign lock_lost_s = sync_b[0];
  assign alarm_s = sync_b[1];
  assign mode_s = sync_b[2];
  assign sleep_s = sync_b[3];

  logic fault_s;
  logic sleep_go;
  assign fault_s = lock_lost_s | alarm_s;
  assign sleep_go = mode_s & sleep_s;

  // last-known-good tuning store
  logic store_we;
  logic next_store_we;
  logic [TUNE_W-1:0] store_rd;
  logic store_valid;
  logic [TUNE_W-1:0] reload_val;

  lis_tune_store #(
    .DEPTH(STORE_DEPTH),
    .WIDTH(TUNE_W)
  ) u_store (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .erase_in(nvm_erase_in),
    .wr_en_in(store_we),
    .wr_data_in(osc_ctl_out.tune),
    .rd_data_out(store_rd),
    .rd_valid_out(store_valid)
  );

  assign reload_val = store_valid ? store_rd : TUNE_NOMINAL;

  // sequencer state
  lis_state_t state;
  lis_state_t next_state;
  logic [STATUS_W-1:0] next_status;
  logic [QUAL_W-1:0] qual_cnt;
  logic [QUAL_W-1:0] next_qual_cnt;
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic tick;
  logic reload;
  lis_osc_ctl_t next_osc_ctl;
  logic next_pin;

  assign tick = (tick_cnt == TICK_LAST); // [RL11]

  always_comb begin
    next_state = state;
    next_status = status_out;
    next_qual_cnt = qual_cnt;
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1; // [RL11]
    next_store_we = 1'b0;
    next_osc_ctl = osc_ctl_out;
    reload = 1'b0;
    // corrections only once status reads zero
    if (status_out == STATUS_LOCKED && corr_in.valid) begin
      next_osc_ctl.tune = sat_add(osc_ctl_out.tune, corr_in.delta); // [RL9]
    end
    unique case (state)
      ST_RESTORE: begin
        reload = 1'b1; // [RL10]
        next_state = ST_ACQUIRE;
      end
      ST_ACQUIRE: begin
        // temperature, optimise and lock stages are walked in status order
        if (step_done_in && status_out != STATUS_LOCKED) begin
          next_status = status_out - STATUS_STEP; // [RL2] [RL3]
          if (status_out == STATUS_STEP) begin
            next_state = ST_QUALIFY;
            next_qual_cnt = '0; // [RL11]
            next_tick_cnt = '0;
          end
        end
      end
      ST_QUALIFY, ST_LOCKED: begin
        if (fault_s) begin
          next_state = ST_ACQUIRE; // [RL6]
          next_status = STATUS_REACQ;
          reload = 1'b1; // [RL10]
        end else if (sleep_go) begin
          next_state = ST_SLEEP; // [RL7]
          next_status = STATUS_REACQ;
        end else if (tick && state == ST_QUALIFY) begin
          if (qual_cnt == QUAL_LAST) begin
            next_state = ST_LOCKED; // [RL5]
          end else begin
            next_qual_cnt = qual_cnt + 1'b1;
          end
        end else if (tick) begin
          next_store_we = 1'b1; // [RL10]
        end
      end
      ST_SLEEP: begin
        if (!sleep_go) begin
          next_state = ST_ACQUIRE; // [RL7]
          reload = 1'b1; // [RL10]
        end
      end
    endcase
    if (reload) begin
      next_osc_ctl.tune = reload_val; // [RL10]
    end
    next_osc_ctl.correct_en = (next_status == STATUS_LOCKED); // [RL9]
    next_pin = (next_state != ST_LOCKED); // [RL4] [RL5] [RL7]
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state <= ST_RESTORE;
      status_out <= STATUS_WARMUP; // [RL1]
      qual_cnt <= '0;
      tick_cnt <= '0;
      store_we <= 1'b0;
      osc_ctl_out <= '{correct_en: 1'b0, tune: TUNE_NOMINAL};
      lock_alarm_pin_out <= 1'b1; // [RL4]
      phase_out <= PH_TEMP;
      freq_out_en_out <= 1'b1; // [RL8]
    end else begin
      state <= next_state;
      status_out <= next_status;
      qual_cnt <= next_qual_cnt;
      tick_cnt <= next_tick_cnt;
      store_we <= next_store_we;
      osc_ctl_out <= next_osc_ctl;
      lock_alarm_pin_out <= next_pin;
      phase_out <= stage_of(next_status); // [RL3]
      freq_out_en_out <= 1'b1; // [RL8]
    end
  end

  // checking helpers
  localparam int QUAL_CYC = QUAL_TICKS * TICK_CYCLES;
  localparam int ALARM_CYC = 3;
  int zero_cnt;
  logic [TUNE_W-1:0] reload_past;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || status_out != STATUS_LOCKED) begin
      zero_cnt <= 0;
    end else if (zero_cnt <= QUAL_CYC) begin
      zero_cnt <= zero_cnt + 1;
    end
    reload_past <= reload_val;
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  a_reset_warmup_code: assert property ( // [RL1]
    @(posedge sys_clk_in) disable iff (1'b0)
    srst_in |=> status_out == STATUS_WARMUP && lock_alarm_pin_out)
    else $error("status not at warm-up code after reset");

  a_status_step_down: assert property ( // [RL2]
    (state == ST_ACQUIRE && step_done_in && status_out != STATUS_LOCKED)
    |=> status_out == $past(status_out) - STATUS_STEP)
    else $error("status did not step down by one");

  a_status_no_skip: assert property ( // [RL2]
    ($past(status_out) > status_out) |-> status_out == $past(status_out) - STATUS_STEP)
    else $error("status skipped a stage");

  a_phase_order: assert property ( // [RL3]
    $changed(phase_out) |->
      (phase_out == lis_phase_t'($past(phase_out) + 2'd1)) || phase_out == PH_LOCK)
    else $error("acquisition phases out of order");

  a_pin_nonzero: assert property ( // [RL4]
    status_out != STATUS_LOCKED |-> lock_alarm_pin_out)
    else $error("alarm pin low while status nonzero");

  a_pin_qualify: assert property ( // [RL5]
    $fell(lock_alarm_pin_out) |-> zero_cnt == QUAL_CYC)
    else $error("lock shown without exact qualification delay");

  a_alarm_fast: assert property ( // [RL6]
    (!lock_alarm_pin_out && fault_s) |-> ##[1:ALARM_CYC] lock_alarm_pin_out)
    else $error("alarm pin slow to rise after fault");

  a_sleep_pin_high: assert property ( // [RL7]
    (state == ST_SLEEP) |-> lock_alarm_pin_out && mode_s ##1 lock_alarm_pin_out)
    else $error("alarm pin low during sleep");

  a_freq_never_gated: assert property ( // [RL8]
    $past(lock_alarm_pin_out) != lock_alarm_pin_out |-> freq_out_en_out)
    else $error("frequency output gated on lock change");

  a_no_correct_unlocked: assert property ( // [RL9]
    (status_out != STATUS_LOCKED && !reload) |=>
      osc_ctl_out.tune == $past(osc_ctl_out.tune) && !$past(osc_ctl_out.correct_en))
    else $error("oscillator corrected while unlocked");

  a_restore_tune: assert property ( // [RL10]
    reload |=> osc_ctl_out.tune == reload_past)
    else $error("last-good tuning not reapplied");

  a_qual_restart: assert property ( // [RL11]
    (state == ST_QUALIFY && $past(state) != ST_QUALIFY) |-> qual_cnt == '0 && tick_cnt == '0)
    else $error("qualification did not restart");

  a_tick_bound: assert property ( // [RL11]
    tick_cnt <= TICK_LAST)
    else $error("second counter out of range");

  a_store_when_locked: assert property ( // [RL10]
    store_we |-> $past(state) == ST_LOCKED)
    else $error("tuning stored while not locked");

  a_pin_tracks_lock: assert property ( // [RL4]
    lock_alarm_pin_out == (state != ST_LOCKED))
    else $error("alarm pin disagrees with lock state");

  a_temp_phase: assert property ( // [RL3]
    status_out >= STATUS_TEMP_LO |-> phase_out == PH_TEMP)
    else $error("temperature stage not reported");

  a_correct_en_locked: assert property ( // [RL9]
    osc_ctl_out.correct_en == (status_out == STATUS_LOCKED))
    else $error("correction enable disagrees with status");

  a_freq_always_on: assert property ( // [RL8]
    freq_out_en_out)
    else $error("frequency output disabled");

  a_sleep_status: assert property ( // [RL7]
    state == ST_SLEEP |-> status_out == STATUS_REACQ)
    else $error("status not nonzero during sleep");

  a_fault_reacquire: assert property ( // [RL6]
    (state == ST_LOCKED && fault_s) |=> status_out == STATUS_REACQ && state == ST_ACQUIRE)
    else $error("fault did not restart acquisition");

  a_restore_warmup: assert property ( // [RL1]
    state == ST_RESTORE |-> status_out == STATUS_WARMUP)
    else $error("status not warm-up code during restore");

  c_power_up_restore: cover property (
    state == ST_RESTORE ##1 store_valid);

  c_reach_lock: cover property (
    $fell(lock_alarm_pin_out));

  c_fault_after_lock: cover property (
    state == ST_LOCKED && fault_s ##1 lock_alarm_pin_out);

  c_sleep_wake: cover property (
    state == ST_SLEEP ##1 state == ST_ACQUIRE);

  c_good_store: cover property (
    store_we ##2 store_valid);

endmodule // lis_lock_indicator

// File: tb/lis_host_model.sv
`timescale 1ns/1ps
// host watching the lock pin: measures how long the pin stays high once status reads zero
module lis_host_model
  import lis_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic lock_alarm_pin_in,
  input wire logic [lis_pkg::STATUS_W-1:0] status_in,
  output int qual_len_out
);
  int cnt;
  logic pin_q;
  initial begin
    cnt = 0;
    pin_q = 1'b1;
    qual_len_out = 0;
  end
  always @(posedge sys_clk_in) begin
    pin_q <= lock_alarm_pin_in;
    if (status_in !== STATUS_LOCKED) begin
      cnt <= 0;
    end else if (lock_alarm_pin_in === 1'b1) begin
      cnt <= cnt + 1;
    end
    // record the count once the pin is seen low after being high
    if (pin_q === 1'b1 && lock_alarm_pin_in === 1'b0) begin
      qual_len_out <= cnt;
    end
  end
endmodule // lis_host_model

// File: tb/tb_lis_lock_indicator.sv
`timescale 1ns/1ps
module tb_lis_lock_indicator;
  import lis_pkg::*;
  localparam int TICK = 20;
  logic sys_clk_in, srst_in, step_done_in, lock_lost_in, alarm_in;
  logic low_power_duty_cycle_mode_in, sleep_req_in, nvm_erase_in;
  lis_corr_t corr_in;
  logic lock_alarm_pin_out, freq_out_en_out;
  logic [STATUS_W-1:0] status_out;
  lis_phase_t phase_out;
  lis_osc_ctl_t osc_ctl_out;
  int qual_len, failures, samples_checked, cycles;
  integer seed = 32'haadb_feb4;
  logic [TUNE_W-1:0] exp_tune;
  logic [TUNE_W-1:0] deltas [8];

  lis_lock_indicator #(.TICK_CYCLES(TICK)) dut (.sys_clk_in, .srst_in, .step_done_in,
    .lock_lost_in, .alarm_in, .low_power_duty_cycle_mode_in, .sleep_req_in, .nvm_erase_in,
    .corr_in, .lock_alarm_pin_out, .status_out, .phase_out, .freq_out_en_out, .osc_ctl_out);
  lis_host_model host (.sys_clk_in, .lock_alarm_pin_in(lock_alarm_pin_out),
    .status_in(status_out), .qual_len_out(qual_len));

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles >= 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: bit %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [TUNE_W-1:0] got, input logic [TUNE_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [1:0] exp_phase(input logic [STATUS_W-1:0] st);
    if (st >= 4'h6) return 2'h0;
    if (st >= 4'h2) return 2'h1;
    if (st != 4'h0) return 2'h2;
    return 2'h3;
  endfunction

  function automatic logic [TUNE_W-1:0] sat(input logic [TUNE_W-1:0] t,
                                            input logic [TUNE_W-1:0] d);
    int s;
    s = int'(t) + int'($signed(d));
    if (s < 0) return 16'h0000;
    if (s > 65535) return 16'hffff;
    return s[TUNE_W-1:0];
  endfunction

  // one step with a correction offered alongside, which must be ignored while unlocked
  task automatic step_once();
    logic [STATUS_W-1:0] st;
    st = status_out;
    step_done_in = 1'b1;
    corr_in = '{1'b1, 16'($random(seed))};
    @(negedge sys_clk_in);
    step_done_in = 1'b0;
    corr_in.valid = 1'b0;
    @(negedge sys_clk_in);
    chk_word(16'(status_out), 16'(st - 4'h1));
    chk_word(16'(phase_out), 16'(exp_phase(status_out)));
    chk_word(osc_ctl_out.tune, exp_tune);
    chk_bit(osc_ctl_out.correct_en, status_out == 4'h0);
    chk_bit(lock_alarm_pin_out, 1'b1);
    repeat (($random(seed) & 3)) @(negedge sys_clk_in);
  endtask

  task automatic walk_down();
    int n;
    n = 0;
    while (status_out !== STATUS_LOCKED && n < 10) begin
      step_once();
      n++;
    end
  endtask

  task automatic qualify();
    int n;
    walk_down();
    n = 0;
    while (lock_alarm_pin_out !== 1'b0 && n < 300) begin
      @(negedge sys_clk_in);
      n++;
    end
    @(negedge sys_clk_in);
    chk_bit(lock_alarm_pin_out, 1'b0);
    chk_word(16'(qual_len), 16'(5 * TICK));
  endtask

  // k: 0 lock lost, 1 alarm, 2 sleep in low-power mode
  task automatic fault(input int k);
    logic [TUNE_W-1:0] good;
    repeat (2 * TICK + 4) @(negedge sys_clk_in);
    good = exp_tune;
    lock_lost_in = (k == 0);
    alarm_in = (k == 1);
    low_power_duty_cycle_mode_in = (k == 2);
    sleep_req_in = (k == 2);
    repeat (4) @(negedge sys_clk_in);
    chk_bit(lock_alarm_pin_out, 1'b1);
    chk_word(16'(status_out), 16'h0001);
    chk_bit(osc_ctl_out.correct_en, 1'b0);
    lock_lost_in = 1'b0;
    alarm_in = 1'b0;
    sleep_req_in = 1'b0;
    repeat (5) @(negedge sys_clk_in);
    chk_word(osc_ctl_out.tune, good);
    chk_bit(lock_alarm_pin_out, 1'b1);
    qualify();
    low_power_duty_cycle_mode_in = 1'b0;
  endtask

  initial begin
    deltas = '{16'h7fff, 16'h7fff, 16'h8000, 16'h8000, 16'h0123, 16'hfff0, 16'h0, 16'h0};
    cycles = 0;
    failures = 0;
    samples_checked = 0;
    {step_done_in, lock_lost_in, alarm_in, low_power_duty_cycle_mode_in, sleep_req_in} = '0;
    corr_in = '{1'b0, 16'h0000};
    srst_in = 1'b1;
    nvm_erase_in = 1'b1;
    exp_tune = TUNE_NOMINAL;
    repeat (8) @(negedge sys_clk_in);
    chk_word(16'(status_out), 16'h0008);
    chk_bit(lock_alarm_pin_out, 1'b1);
    chk_word(16'(phase_out), 16'(PH_TEMP));
    chk_bit(freq_out_en_out, 1'b1);
    chk_word(osc_ctl_out.tune, 16'h8000);
    srst_in = 1'b0;
    nvm_erase_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    walk_down();
    repeat (30) @(negedge sys_clk_in);
    chk_bit(lock_alarm_pin_out, 1'b1);
    alarm_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    chk_word(16'(status_out), 16'h0001);
    alarm_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    qualify();
    deltas[6] = 16'($random(seed));
    deltas[7] = 16'($random(seed));
    foreach (deltas[i]) begin
      corr_in = '{1'b1, deltas[i]};
      @(negedge sys_clk_in);
      exp_tune = sat(exp_tune, deltas[i]);
      chk_word(osc_ctl_out.tune, exp_tune);
    end
    corr_in.valid = 1'b0;
    for (int k = 0; k < 3; k++) begin
      fault(k);
    end
    chk_bit(freq_out_en_out, 1'b1);
    // warm restart: the store keeps the last good tuning across reset
    srst_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    srst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk_word(16'(status_out), 16'h0008);
    chk_word(osc_ctl_out.tune, exp_tune);
    chk_bit(lock_alarm_pin_out, 1'b1);
    end_of_test();
  end
endmodule // tb_lis_lock_indicator
